// File: bcbl_cond_eval.sv
// Branch condition evaluator: decides taken from the four flags
`timescale 1ns/1ns
`default_nettype none

module bcbl_cond_eval (
  bcbl_cond_if.evaluator condPort
);

  logic signedLess;

  always_comb begin
    signedLess = condPort.flagN ^ condPort.flagV;
    case (condPort.cond)
      bcbl_pkg::BRANCH_ALWAYS:         condPort.taken = 1'b1;
      bcbl_pkg::BRANCH_NEVER:          condPort.taken = 1'b0;
      bcbl_pkg::BRANCH_IF_HIGHER:      condPort.taken = !(condPort.flagC | condPort.flagZ);
      bcbl_pkg::BRANCH_IF_LOWER_SAME:  condPort.taken = condPort.flagC | condPort.flagZ;
      bcbl_pkg::BRANCH_IF_HIGHER_SAME: condPort.taken = !condPort.flagC;
      bcbl_pkg::BRANCH_IF_LOWER:       condPort.taken = condPort.flagC;
      bcbl_pkg::BRANCH_IF_NOT_EQUAL:   condPort.taken = !condPort.flagZ;
      bcbl_pkg::BRANCH_IF_EQUAL:       condPort.taken = condPort.flagZ;
      bcbl_pkg::BRANCH_IF_NO_OVERFLOW: condPort.taken = !condPort.flagV;
      bcbl_pkg::BRANCH_IF_OVERFLOW:    condPort.taken = condPort.flagV;
      bcbl_pkg::BRANCH_IF_PLUS:        condPort.taken = !condPort.flagN;
      bcbl_pkg::BRANCH_IF_MINUS:       condPort.taken = condPort.flagN;
      bcbl_pkg::BRANCH_IF_SIGNED_GE:   condPort.taken = !signedLess;
      bcbl_pkg::BRANCH_IF_SIGNED_LT:   condPort.taken = signedLess;
      bcbl_pkg::BRANCH_IF_SIGNED_GT:   condPort.taken = !(condPort.flagZ | signedLess);
      bcbl_pkg::BRANCH_IF_SIGNED_LE:   condPort.taken = condPort.flagZ | signedLess;
      default:                         condPort.taken = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// File: bcbl_cond_if.sv
// Flag and condition bundle between the core and its condition evaluator
`timescale 1ns/1ns
`default_nettype none

interface bcbl_cond_if;
  logic                  flagC;
  logic                  flagZ;
  logic                  flagV;
  logic                  flagN;
  bcbl_pkg::bcbl_cond_t  cond;
  logic                  taken;

  modport evaluator (input flagC, input flagZ, input flagV, input flagN, input cond,
                     output taken);
  modport requester (output flagC, output flagZ, output flagV, output flagN, output cond,
                     input taken);
endinterface

`default_nettype wire

// File: bcbl_core.sv
// Carry-flag bit operations, branch condition handling, jumps, calls and returns
// Summary of operation
// - Carry-OR: carry becomes carry OR the selected operand bit.
// - Inverted carry-OR: carry becomes carry OR the inverted selected bit.
// - Carry-XOR: carry becomes carry XOR the selected operand bit.
// - Inverted carry-XOR: carry becomes carry XOR the inverted selected bit.
// - Bit load: selected operand bit is copied into carry.
// - Inverted bit load: inverted selected bit is copied into carry.
// - Bit store: carry written into selected bit, other bits kept.
// - Inverted bit store: inverted carry written into selected bit.
// - Inverted forms take the bit number only from the 3-bit immediate.
// - Conditional branch loads target when true; always and never forms fixed.
// - Unsigned conditions: higher, lower-or-same, higher-or-same, lower from C and Z.
// - Single-flag conditions on Z, V and N, each clear or set.
// - Signed conditions from N XOR V, and Z OR (N XOR V).
// - Jump loads its target unconditionally, no flags examined.
// - Calls save the return address and go to the subroutine in the same cycle.
`timescale 1ns/1ns
`default_nettype none

module bcbl_core (
  input  wire  logic                                sys_clk,
  input  wire  logic                                rst,
  input  wire  logic                                opValid,
  input  wire  bcbl_pkg::bcbl_op_t                  opCode,
  input  wire  bcbl_pkg::bcbl_cond_t                condCode,
  input  wire  logic [bcbl_pkg::BIT_W-1:0]          bitImm,
  input  wire  logic [bcbl_pkg::BIT_W-1:0]          bitReg,
  input  wire  logic                                bitNumIsReg,
  input  wire  logic [bcbl_pkg::DATA_W-1:0]         operand,
  input  wire  logic                                flagC,
  input  wire  logic                                flagZ,
  input  wire  logic                                flagV,
  input  wire  logic                                flagN,
  input  wire  logic [bcbl_pkg::ADDR_W-1:0]         pcNext,
  input  wire  logic [bcbl_pkg::DISP_W-1:0]         dispRel,
  input  wire  logic [bcbl_pkg::ADDR_W-1:0]         targetAbs,
  output logic                                      carryWe,
  output logic                                      carryOut,
  output logic                                      resultWe,
  output logic [bcbl_pkg::DATA_W-1:0]               resultByte,
  output logic                                      pcWe,
  output logic [bcbl_pkg::ADDR_W-1:0]               pcNew,
  output logic                                      branchTaken,
  output logic                                      retWe,
  output logic [bcbl_pkg::ADDR_W-1:0]               retAddr,
  output logic                                      done,
  output logic                                      fault
);

  typedef struct packed {
    logic                                           carryWe;
    logic                                           carry;
    logic                                           resultWe;
    logic [bcbl_pkg::DATA_W-1:0]                    result;
    logic                                           pcWe;
    logic [bcbl_pkg::ADDR_W-1:0]                    pcNew;
    logic                                           taken;
    logic                                           retWe;
    logic [bcbl_pkg::ADDR_W-1:0]                    retAddr;
    logic                                           done;
    logic                                           fault;
    logic [bcbl_pkg::DEPTH-1:0][bcbl_pkg::ADDR_W-1:0] stack;
    logic [bcbl_pkg::PTR_W-1:0]                     wrPtr;
    logic [bcbl_pkg::COUNT_W-1:0]                   count;
  } bcbl_state_t;

  bcbl_state_t                   st;
  bcbl_state_t                   next_st;
  logic                          effCarry;
  logic [bcbl_pkg::BIT_W-1:0]    bitIdx;
  logic                          curBit;
  logic                          srcBit;
  logic [bcbl_pkg::ADDR_W-1:0]   relTarget;
  logic [bcbl_pkg::PTR_W-1:0]    topPtr;

  bcbl_cond_if condBus ();

  // Register-held bit number is honoured only by the plain forms
  function automatic logic [bcbl_pkg::BIT_W-1:0] pick_index(
    input bcbl_pkg::bcbl_op_t         op,
    input logic                       isReg,
    input logic [bcbl_pkg::BIT_W-1:0] regIdx,
    input logic [bcbl_pkg::BIT_W-1:0] immIdx
  );
    return (isReg && !bcbl_pkg::is_inverted(op)) ? regIdx : immIdx;
  endfunction

  assign condBus.flagC = effCarry;
  assign condBus.flagZ = flagZ;
  assign condBus.flagV = flagV;
  assign condBus.flagN = flagN;
  assign condBus.cond  = condCode;

  bcbl_cond_eval uCondEval (
    .condPort (condBus.evaluator)
  );

  // The flag register sees our carry write one cycle late, so forward it
  assign effCarry = st.carryWe ? st.carry : flagC;

  always_comb begin
    bitIdx    = pick_index(opCode, bitNumIsReg, bitReg, bitImm);
    curBit    = operand[bitIdx];
    srcBit    = bcbl_pkg::is_inverted(opCode) ? !curBit : curBit;
    relTarget = pcNext + {{(bcbl_pkg::ADDR_W-bcbl_pkg::DISP_W){dispRel[bcbl_pkg::DISP_W-1]}},
                          dispRel};
    topPtr    = st.wrPtr - bcbl_pkg::PTR_STEP;
    next_st          = st;
    next_st.carryWe  = 1'b0;
    next_st.resultWe = 1'b0;
    next_st.pcWe     = 1'b0;
    next_st.taken    = 1'b0;
    next_st.retWe    = 1'b0;
    next_st.done     = 1'b0;
    next_st.fault    = 1'b0;
    if (opValid) begin
      next_st.done = 1'b1;
      case (opCode)
        bcbl_pkg::CARRY_OR_BIT_OP, bcbl_pkg::CARRY_OR_INV_BIT_OP: begin
          next_st.carryWe = 1'b1;
          next_st.carry   = effCarry | srcBit;
        end
        bcbl_pkg::CARRY_XOR_BIT_OP, bcbl_pkg::CARRY_XOR_INV_BIT_OP: begin
          next_st.carryWe = 1'b1;
          next_st.carry   = effCarry ^ srcBit;
        end
        bcbl_pkg::BIT_TO_CARRY_OP, bcbl_pkg::INV_BIT_TO_CARRY_OP: begin
          next_st.carryWe = 1'b1;
          next_st.carry   = srcBit;
        end
        bcbl_pkg::CARRY_TO_BIT_OP, bcbl_pkg::INV_CARRY_TO_BIT_OP: begin
          next_st.resultWe = 1'b1;
          for (int i = 0; i < bcbl_pkg::DATA_W; i++) begin
            if (bcbl_pkg::BIT_W'(i) == bitIdx) begin
              next_st.result[i] = bcbl_pkg::is_inverted(opCode) ? !effCarry
                                                                : effCarry;
            end else begin
              next_st.result[i] = operand[i];
            end
          end
        end
        bcbl_pkg::COND_BRANCH_OP: begin
          // Fall-through also writes the sequential address so the fetcher needs one path
          next_st.pcWe  = 1'b1;
          next_st.taken = condBus.taken;
          next_st.pcNew = condBus.taken ? relTarget : pcNext;
        end
        bcbl_pkg::JUMP_OP: begin
          next_st.pcWe  = 1'b1;
          next_st.taken = 1'b1;
          next_st.pcNew = targetAbs;
        end
        bcbl_pkg::RELATIVE_CALL_OP, bcbl_pkg::ABSOLUTE_CALL_OP: begin
          next_st.retWe    = 1'b1;
          next_st.retAddr  = pcNext;
          next_st.stack[st.wrPtr] = pcNext;
          next_st.wrPtr    = st.wrPtr + bcbl_pkg::PTR_STEP;
          // A full stack overwrites its oldest entry; deep nesting loses the oldest return
          if (st.count != bcbl_pkg::COUNT_FULL) begin
            next_st.count = st.count + bcbl_pkg::COUNT_STEP;
          end
          next_st.pcWe  = 1'b1;
          next_st.taken = 1'b1;
          next_st.pcNew = (opCode == bcbl_pkg::RELATIVE_CALL_OP) ? relTarget : targetAbs;
        end
        bcbl_pkg::SUBR_RETURN_OP: begin
          if (st.count == bcbl_pkg::COUNT_RESET) begin
            next_st.fault = 1'b1;
          end else begin
            next_st.pcWe  = 1'b1;
            next_st.taken = 1'b1;
            next_st.pcNew = st.stack[topPtr];
            next_st.wrPtr = topPtr;
            next_st.count = st.count - bcbl_pkg::COUNT_STEP;
          end
        end
        default: begin
          next_st.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st          <= '0;
      st.result   <= bcbl_pkg::BYTE_RESET;
      st.pcNew    <= bcbl_pkg::PC_RESET;
      st.retAddr  <= bcbl_pkg::PC_RESET;
      st.wrPtr    <= bcbl_pkg::PTR_RESET;
      st.count    <= bcbl_pkg::COUNT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign carryWe     = st.carryWe;
  assign carryOut    = st.carry;
  assign resultWe    = st.resultWe;
  assign resultByte  = st.result;
  assign pcWe        = st.pcWe;
  assign pcNew       = st.pcNew;
  assign branchTaken = st.taken;
  assign retWe       = st.retWe;
  assign retAddr     = st.retAddr;
  assign done        = st.done;
  assign fault       = st.fault;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_carry_or;
    opValid && opCode == bcbl_pkg::CARRY_OR_BIT_OP
      |=> carryWe && carryOut == ($past(effCarry) | $past(operand[bitIdx]));
  endproperty
  a_carry_or: assert property (p_carry_or)
    else $error("carry OR result wrong");

  property p_carry_or_inv;
    opValid && opCode == bcbl_pkg::CARRY_OR_INV_BIT_OP
      |=> carryWe && carryOut == ($past(effCarry) | !$past(operand[bitImm]));
  endproperty
  a_carry_or_inv: assert property (p_carry_or_inv)
    else $error("inverted carry OR result wrong");

  property p_carry_xor;
    opValid && opCode == bcbl_pkg::CARRY_XOR_BIT_OP
      |=> carryWe && carryOut == ($past(effCarry) ^ $past(operand[bitIdx]));
  endproperty
  a_carry_xor: assert property (p_carry_xor)
    else $error("carry XOR result wrong");

  property p_carry_xor_inv;
    opValid && opCode == bcbl_pkg::CARRY_XOR_INV_BIT_OP
      |=> carryWe && carryOut == ($past(effCarry) ^ !$past(operand[bitImm]));
  endproperty
  a_carry_xor_inv: assert property (p_carry_xor_inv)
    else $error("inverted carry XOR result wrong");

  property p_bit_load;
    opValid && opCode == bcbl_pkg::BIT_TO_CARRY_OP
      |=> carryWe && carryOut == $past(operand[bitIdx]) && !resultWe;
  endproperty
  a_bit_load: assert property (p_bit_load)
    else $error("bit load did not copy operand bit");

  property p_bit_load_inv;
    opValid && opCode == bcbl_pkg::INV_BIT_TO_CARRY_OP
      |=> carryWe && carryOut == !$past(operand[bitImm]);
  endproperty
  a_bit_load_inv: assert property (p_bit_load_inv)
    else $error("inverted bit load wrong");

  property p_bit_store;
    opValid && opCode == bcbl_pkg::CARRY_TO_BIT_OP
      |=> resultWe && !carryWe && resultByte[$past(bitIdx)] == $past(effCarry)
          && ((resultByte ^ $past(operand)) & ~(8'h01 << $past(bitIdx))) == 8'h00;
  endproperty
  a_bit_store: assert property (p_bit_store)
    else $error("bit store wrong or disturbed other bits");

  property p_bit_store_inv;
    opValid && opCode == bcbl_pkg::INV_CARRY_TO_BIT_OP
      |=> resultWe && resultByte[$past(bitImm)] == !$past(effCarry);
  endproperty
  a_bit_store_inv: assert property (p_bit_store_inv)
    else $error("inverted bit store wrong");

  property p_branch_fixed;
    opValid && opCode == bcbl_pkg::COND_BRANCH_OP && condCode == bcbl_pkg::BRANCH_NEVER
      |=> pcWe && !branchTaken && pcNew == $past(pcNext);
  endproperty
  a_branch_fixed: assert property (p_branch_fixed)
    else $error("never-branch was taken");

  property p_branch_unsigned;
    opValid && opCode == bcbl_pkg::COND_BRANCH_OP && condCode == bcbl_pkg::BRANCH_IF_HIGHER
      |=> branchTaken == !($past(effCarry) | $past(flagZ));
  endproperty
  a_branch_unsigned: assert property (p_branch_unsigned)
    else $error("higher condition misjudged");

  property p_branch_single;
    opValid && opCode == bcbl_pkg::COND_BRANCH_OP && condCode == bcbl_pkg::BRANCH_IF_OVERFLOW
      |=> branchTaken == $past(flagV) && pcNew == ($past(flagV) ? $past(relTarget)
                                                               : $past(pcNext));
  endproperty
  a_branch_single: assert property (p_branch_single)
    else $error("overflow-set branch wrong");

  property p_branch_signed;
    opValid && opCode == bcbl_pkg::COND_BRANCH_OP && condCode == bcbl_pkg::BRANCH_IF_SIGNED_LE
      |=> branchTaken == ($past(flagZ) | ($past(flagN) ^ $past(flagV)));
  endproperty
  a_branch_signed: assert property (p_branch_signed)
    else $error("less-or-equal condition misjudged");

  property p_jump;
    opValid && opCode == bcbl_pkg::JUMP_OP |=> pcWe && pcNew == $past(targetAbs) && !retWe;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not loaded");

  property p_call;
    opValid && opCode == bcbl_pkg::ABSOLUTE_CALL_OP
      |=> retWe && retAddr == $past(pcNext) && pcWe && pcNew == $past(targetAbs);
  endproperty
  a_call: assert property (p_call)
    else $error("call did not save return address");

  property p_call_return;
    opValid && opCode == bcbl_pkg::RELATIVE_CALL_OP
      ##1 opValid && opCode == bcbl_pkg::SUBR_RETURN_OP
      |=> pcWe && pcNew == $past(pcNext, 2);
  endproperty
  a_call_return: assert property (p_call_return)
    else $error("return did not resume at saved address");

endmodule

`default_nettype wire

// File: bcbl_core_tb.sv
// Self-checking testbench for the carry-bit and branch core
`timescale 1ns/1ns
`default_nettype none

module bcbl_core_tb;
  typedef struct {
    logic        cWe;
    logic        cOut;
    logic        rWe;
    logic [7:0]  rByte;
    logic        pWe;
    logic [23:0] pNew;
    logic        bTak;
    logic        retWe;
    logic [23:0] ret;
    logic        flt;
  } bcbl_exp_t;

  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 opValid = 1'b0;
  bcbl_pkg::bcbl_op_t   opCode = bcbl_pkg::NO_OP;
  bcbl_pkg::bcbl_cond_t condCode = bcbl_pkg::BRANCH_ALWAYS;
  logic [2:0]           bitImm = 3'h0;
  logic [2:0]           bitReg = 3'h0;
  logic                 bitNumIsReg = 1'b0;
  logic [7:0]           operand = 8'h00;
  logic                 flagC = 1'b0;
  logic                 flagZ = 1'b0;
  logic                 flagV = 1'b0;
  logic                 flagN = 1'b0;
  logic [23:0]          pcNext = 24'h000000;
  logic [15:0]          dispRel = 16'h0000;
  logic [23:0]          targetAbs = 24'h000000;
  logic                 carryWe, carryOut, resultWe, pcWe, branchTaken, retWe, done, fault;
  logic [7:0]           resultByte;
  logic [23:0]          pcNew, retAddr;
  logic [31:0]          lfsr = 32'h0da64649;
  logic                 cModel = 1'b0;
  logic                 prevWrote = 1'b0;
  logic [4:0]           condSel = 5'h10;
  logic [23:0]          stk[$];
  bcbl_exp_t            expq[$];
  bcbl_exp_t            m;
  int                   mismatches = 0;
  int                   check_count = 0;

  bcbl_core u_bcbl_core (.sys_clk(sys_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .condCode(condCode), .bitImm(bitImm), .bitReg(bitReg), .bitNumIsReg(bitNumIsReg),
    .operand(operand), .flagC(flagC), .flagZ(flagZ), .flagV(flagV), .flagN(flagN),
    .pcNext(pcNext), .dispRel(dispRel), .targetAbs(targetAbs), .carryWe(carryWe),
    .carryOut(carryOut), .resultWe(resultWe), .resultByte(resultByte), .pcWe(pcWe),
    .pcNew(pcNew), .branchTaken(branchTaken), .retWe(retWe), .retAddr(retAddr),
    .done(done), .fault(fault));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] nextRnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h00000000);
    return lfsr;
  endfunction

  function automatic logic condTrue(bcbl_pkg::bcbl_cond_t cc, logic c, logic z, logic v,
                                    logic n);
    case (cc)
      bcbl_pkg::BRANCH_ALWAYS:         return 1'b1;
      bcbl_pkg::BRANCH_NEVER:          return 1'b0;
      bcbl_pkg::BRANCH_IF_HIGHER:      return (c | z) == 1'b0;
      bcbl_pkg::BRANCH_IF_LOWER_SAME:  return (c | z) == 1'b1;
      bcbl_pkg::BRANCH_IF_HIGHER_SAME: return c == 1'b0;
      bcbl_pkg::BRANCH_IF_LOWER:       return c == 1'b1;
      bcbl_pkg::BRANCH_IF_NOT_EQUAL:   return z == 1'b0;
      bcbl_pkg::BRANCH_IF_EQUAL:       return z == 1'b1;
      bcbl_pkg::BRANCH_IF_NO_OVERFLOW: return v == 1'b0;
      bcbl_pkg::BRANCH_IF_OVERFLOW:    return v == 1'b1;
      bcbl_pkg::BRANCH_IF_PLUS:        return n == 1'b0;
      bcbl_pkg::BRANCH_IF_MINUS:       return n == 1'b1;
      bcbl_pkg::BRANCH_IF_SIGNED_GE:   return (n ^ v) == 1'b0;
      bcbl_pkg::BRANCH_IF_SIGNED_LT:   return (n ^ v) == 1'b1;
      bcbl_pkg::BRANCH_IF_SIGNED_GT:   return (z | (n ^ v)) == 1'b0;
      default:                         return (z | (n ^ v)) == 1'b1;
    endcase
  endfunction

  task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One instruction slot; the expectation is noted at drive time
  task automatic issue(bcbl_pkg::bcbl_op_t op, logic vld);
    logic [31:0] r1, r2;
    logic [23:0] rel;
    logic [2:0]  idx;
    logic        b, c, inv;
    bcbl_exp_t   e;
    @(posedge sys_clk);
    #1;
    r1 = nextRnd();
    r2 = nextRnd();
    opValid = vld;
    opCode = op;
    condCode = condSel[4] ? bcbl_pkg::bcbl_cond_t'(r1[7:4])
                          : bcbl_pkg::bcbl_cond_t'(condSel[3:0]);
    {bitNumIsReg, bitReg, bitImm} = r1[14:8];
    operand = r1[22:15];
    {flagN, flagV, flagZ} = r1[25:23];
    dispRel = r2[15:0];
    pcNext = {r2[31:16], r1[31:24]};
    targetAbs = r1[23:0] ^ r2[31:8];
    // A carry written one slot earlier must be forwarded, so show the stale opposite
    flagC = prevWrote ? ~cModel : cModel;
    e = '{default: '0};
    rel = pcNext + {{8{dispRel[15]}}, dispRel};
    inv = op inside {bcbl_pkg::CARRY_OR_INV_BIT_OP, bcbl_pkg::CARRY_XOR_INV_BIT_OP,
                     bcbl_pkg::INV_BIT_TO_CARRY_OP, bcbl_pkg::INV_CARRY_TO_BIT_OP};
    idx = (bitNumIsReg && !inv) ? bitReg : bitImm;
    b = operand[idx];
    c = cModel;
    e.rByte = operand;
    if (vld) begin
      case (op)
        bcbl_pkg::CARRY_OR_BIT_OP:      {e.cWe, e.cOut} = {1'b1, c | b};
        bcbl_pkg::CARRY_OR_INV_BIT_OP:  {e.cWe, e.cOut} = {1'b1, c | ~b};
        bcbl_pkg::CARRY_XOR_BIT_OP:     {e.cWe, e.cOut} = {1'b1, c ^ b};
        bcbl_pkg::CARRY_XOR_INV_BIT_OP: {e.cWe, e.cOut} = {1'b1, c ^ ~b};
        bcbl_pkg::BIT_TO_CARRY_OP:      {e.cWe, e.cOut} = {1'b1, b};
        bcbl_pkg::INV_BIT_TO_CARRY_OP:  {e.cWe, e.cOut} = {1'b1, ~b};
        bcbl_pkg::CARRY_TO_BIT_OP:      {e.rWe, e.rByte[idx]} = {1'b1, c};
        bcbl_pkg::INV_CARRY_TO_BIT_OP:  {e.rWe, e.rByte[idx]} = {1'b1, ~c};
        bcbl_pkg::COND_BRANCH_OP: begin
          e.bTak = condTrue(condCode, c, flagZ, flagV, flagN);
          {e.pWe, e.pNew} = {1'b1, e.bTak ? rel : pcNext};
        end
        bcbl_pkg::JUMP_OP: {e.pWe, e.bTak, e.pNew} = {2'b11, targetAbs};
        bcbl_pkg::RELATIVE_CALL_OP, bcbl_pkg::ABSOLUTE_CALL_OP: begin
          {e.retWe, e.ret, e.pWe, e.bTak} = {1'b1, pcNext, 2'b11};
          e.pNew = (op == bcbl_pkg::ABSOLUTE_CALL_OP) ? targetAbs : rel;
          stk.push_back(pcNext);
          if (stk.size() > 8) void'(stk.pop_front());
        end
        bcbl_pkg::SUBR_RETURN_OP: begin
          if (stk.size() == 0) e.flt = 1'b1;
          else {e.pWe, e.bTak, e.pNew} = {2'b11, stk.pop_back()};
        end
        default: ;
      endcase
      if (op >= bcbl_pkg::CARRY_OR_BIT_OP && op <= bcbl_pkg::SUBR_RETURN_OP) expq.push_back(e);
    end
    if (e.cWe) cModel = e.cOut;
    prevWrote = e.cWe;
  endtask

  always @(negedge sys_clk) begin
    if (!rst && done !== 1'b1 &&
        {carryWe, resultWe, pcWe, retWe, fault, branchTaken} !== 6'h00) begin
      mismatches++;
      $display("MISMATCH strobes expected 000000 seen %b",
               {carryWe, resultWe, pcWe, retWe, fault, branchTaken});
    end
    if (!rst && done === 1'b1) begin
      if (expq.size() == 0) chk("done", 24'h0, {23'h0, done});
      else begin
        m = expq.pop_front();
        chk("carryWe", {23'h0, m.cWe}, {23'h0, carryWe});
        if (m.cWe) chk("carryOut", {23'h0, m.cOut}, {23'h0, carryOut});
        chk("resultWe", {23'h0, m.rWe}, {23'h0, resultWe});
        if (m.rWe) chk("resultByte", {16'h0, m.rByte}, {16'h0, resultByte});
        chk("pcWe", {23'h0, m.pWe}, {23'h0, pcWe});
        chk("branchTaken", {23'h0, m.bTak}, {23'h0, branchTaken});
        if (m.pWe) chk("pcNew", m.pNew, pcNew);
        chk("retWe", {23'h0, m.retWe}, {23'h0, retWe});
        if (m.retWe) chk("retAddr", m.ret, retAddr);
        chk("fault", {23'h0, m.flt}, {23'h0, fault});
      end
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    @(negedge sys_clk);
    chk("resetOut", 24'h0, pcNew | retAddr | {16'h0, resultByte} | {23'h0, done});
    issue(bcbl_pkg::SUBR_RETURN_OP, 1'b1);
    // Ten nested calls overflow the 8-deep save area; the ninth return must fault
    for (int i = 0; i < 10; i++) issue(bcbl_pkg::RELATIVE_CALL_OP, 1'b1);
    for (int i = 0; i < 9; i++) issue(bcbl_pkg::SUBR_RETURN_OP, 1'b1);
    // Each condition twice, right after a carry load so the branch sees the forwarded carry
    for (int i = 0; i < 32; i++) begin
      condSel = {1'b0, i[3:0]};
      issue(bcbl_pkg::BIT_TO_CARRY_OP, 1'b1);
      issue(bcbl_pkg::COND_BRANCH_OP, 1'b1);
    end
    condSel = 5'h10;
    for (int i = 0; i < 800; i++) begin
      r = nextRnd();
      issue(bcbl_pkg::bcbl_op_t'(r[3:0]), r[31:29] != 3'h0);
    end
    issue(bcbl_pkg::NO_OP, 1'b0);
    for (int i = 0; i < 5 && expq.size() > 0; i++) @(posedge sys_clk);
    chk("pending", 24'h0, 24'(expq.size()));
    summarize();
  end
endmodule

`default_nettype wire

// File: bcbl_pkg.sv
// Shared constants, opcodes and condition encodings for the carry-bit and branch unit
package bcbl_pkg;

  localparam int ADDR_W  = 24;
  localparam int DATA_W  = 8;
  localparam int BIT_W   = 3;
  localparam int DISP_W  = 16;
  localparam int DEPTH   = 8;
  localparam int PTR_W   = 3;
  localparam int COUNT_W = 4;

  // Results appear this many clock edges after the issue edge
  localparam int RESULT_LATENCY = 1;

  localparam logic [ADDR_W-1:0]  PC_RESET    = 24'h000000;
  localparam logic [DATA_W-1:0]  BYTE_RESET  = 8'h00;
  localparam logic [PTR_W-1:0]   PTR_RESET   = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;
  localparam logic [COUNT_W-1:0] COUNT_FULL  = 4'h8;
  localparam logic [PTR_W-1:0]   PTR_STEP    = 3'h1;
  localparam logic [COUNT_W-1:0] COUNT_STEP  = 4'h1;

  typedef enum logic [3:0] {
    NO_OP,
    CARRY_OR_BIT_OP,
    CARRY_OR_INV_BIT_OP,
    CARRY_XOR_BIT_OP,
    CARRY_XOR_INV_BIT_OP,
    BIT_TO_CARRY_OP,
    INV_BIT_TO_CARRY_OP,
    CARRY_TO_BIT_OP,
    INV_CARRY_TO_BIT_OP,
    COND_BRANCH_OP,
    JUMP_OP,
    RELATIVE_CALL_OP,
    ABSOLUTE_CALL_OP,
    SUBR_RETURN_OP
  } bcbl_op_t;

  typedef enum logic [3:0] {
    BRANCH_ALWAYS,
    BRANCH_NEVER,
    BRANCH_IF_HIGHER,
    BRANCH_IF_LOWER_SAME,
    BRANCH_IF_HIGHER_SAME,
    BRANCH_IF_LOWER,
    BRANCH_IF_NOT_EQUAL,
    BRANCH_IF_EQUAL,
    BRANCH_IF_NO_OVERFLOW,
    BRANCH_IF_OVERFLOW,
    BRANCH_IF_PLUS,
    BRANCH_IF_MINUS,
    BRANCH_IF_SIGNED_GE,
    BRANCH_IF_SIGNED_LT,
    BRANCH_IF_SIGNED_GT,
    BRANCH_IF_SIGNED_LE
  } bcbl_cond_t;

  // Inverted-operand forms share both the bit inversion and the immediate-only index
  function automatic logic is_inverted(input bcbl_op_t op);
    return (op == CARRY_OR_INV_BIT_OP) || (op == CARRY_XOR_INV_BIT_OP) ||
           (op == INV_BIT_TO_CARRY_OP) || (op == INV_CARRY_TO_BIT_OP);
  endfunction

endpackage
